// [src/main_clock_controller.sv]
// main clock controller: source select, safe switching, prescaler, oscillator gating
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - main clock runs always in active and idle modes
// - in standby main clock runs only on request or keep-running bit
// - power-down stops main clock only after nonvolatile operations finish
// - unrequested clock sources are switched off
// - keep-running oscillator stays on except power-down, skips analog start-up
// - external switch completes only after enough edges seen
// - waiting for external clock ignores further selects until reset
// - flags for switch pending and external clock started
// - peripheral clock is main root divided by 1 to 64
// - reset selects fast oscillator and divide by six
// - fast oscillator runs at 16 or 20 MHz per fuse
// - reset loads center and slope trims from fuses
// - calibration blocked by fuse lock or lock enable on fast root
// - fast oscillator gated for analog start-up plus four cycles
// - frequency error is 8-bit signed compressed Q1.10
// - slow oscillator gives 1.024 kHz to counter, watchdog, brown-out
// - unit clocks requested automatically when those units are enabled
// - external pin becomes clock input whenever external clock requested
// - external clock start-up is two cycles on first request
// - protected write without unlock leaves register unchanged
// - select code 0 fast, 1 slow, 3 external, 2 reserved
module main_clock_controller #(
  parameter logic [7:0] UNLOCK_KEY = clk_ctrl_pkg::UNLOCK_KEY_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire clk_ctrl_pkg::sleep_mode_t sleep_mode,
  input wire logic nvm_busy,
  input wire clk_ctrl_pkg::periph_req_t periph_req,
  input wire clk_ctrl_pkg::fuse_cfg_t fuse_cfg,
  input wire clk_ctrl_pkg::osc_in_t osc_in,
  output clk_ctrl_pkg::osc_ctrl_t osc_ctrl_ff,
  output logic [1:0] main_root_sel_ff,
  output logic main_clock_run_ff,
  output logic per_clock_tick_ff,
  output logic clock_output_pin_ff,
  output logic rtc_clock_tick_ff,
  output logic watchdog_clock_ff,
  output logic brownout_clock_ff,
  output logic [10:0] freq_error_q110_ff
);
  import clk_ctrl_pkg::*;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_EXT_WAIT} sw_state_t;

  sw_state_t sw_state_ff;
  logic [1:0] target_ff;
  logic pending_ff;
  logic init_done_ff;
  logic clock_output_pin_en_ff;
  logic [3:0] pdiv_ff;
  logic pen_ff;
  logic lock_en_ff;
  logic cal_lock_ff;
  logic fast_keep_ff;
  logic slow_keep_ff;
  logic [5:0] center_trim_ff;
  logic [3:0] temp_trim_ff;
  logic [2:0] protect_cnt_ff;
  logic [6:0] div_cnt_ff;
  logic [KHZ_DIV_W-1:0] khz_cnt_ff;
  logic fast_stable;
  logic slow_stable;
  logic ext_stable;
  logic [7:0] idx;
  logic setup;
  logic access_done;
  logic wr;
  logic unlocked;
  logic sel_wr;
  logic cal_blocked;
  logic target_stable;
  logic keep_allowed;
  logic need_fast;
  logic need_slow;
  logic need_ext;
  logic main_run_nxt;
  logic root_tick;
  logic [6:0] factor;
  logic [7:0] rd_data;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////
  // apb decode; one-cycle access phase, answer registered at setup
  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign access_done = psel & penable & pready_ff;
  assign wr = access_done & pwrite & ~pslverr_ff;
  assign unlocked = (protect_cnt_ff != 3'h0);
  assign sel_wr = wr & unlocked & (idx == IDX_MAIN_CTRL_A) & ~lock_en_ff;
  assign cal_blocked = cal_lock_ff | ((main_root_sel_ff == SRC_FAST) & lock_en_ff);

  // read mux; status reflects live oscillator gates
  always_comb
  begin
    rd_data = 8'h00;
    rd_hit = (paddr[1:0] == 2'b00) & (paddr[11:10] == 2'b00);
    case (idx)
      IDX_MAIN_CTRL_A: rd_data = {clock_output_pin_en_ff, 5'h00, target_ff};
      IDX_MAIN_CTRL_B: rd_data = {3'h0, pdiv_ff, pen_ff};
      IDX_MAIN_LOCK: rd_data = {7'h00, lock_en_ff};
      IDX_MAIN_STATUS:
      begin
        rd_data[EXT_CLOCK_STARTED_BIT] = ext_stable;
        rd_data[SLOW_STABLE_BIT] = slow_stable;
        rd_data[FAST_STABLE_BIT] = fast_stable;
        rd_data[0] = pending_ff;
      end
      IDX_FAST_CTRL_A: rd_data[KEEP_BIT] = fast_keep_ff;
      IDX_FAST_CALIB_A: rd_data = {2'h0, center_trim_ff};
      IDX_FAST_CALIB_B: rd_data = {cal_lock_ff, 3'h0, temp_trim_ff};
      IDX_SLOW_CTRL_A: rd_data[KEEP_BIT] = slow_keep_ff;
      IDX_FREQ_ERROR: rd_data = freq_error_q110_ff[7:0];
      IDX_PROTECT: rd_data = {5'h00, protect_cnt_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= setup;
      prdata_ff <= (setup && !pwrite && rd_hit) ? {24'h00_0000, rd_data} : 32'h0000_0000;
      pslverr_ff <= setup & ~rd_hit;
    end
  end

  // unlock window; a fresh key write wins over the countdown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      protect_cnt_ff <= 3'h0;
    else if (wr && idx == IDX_PROTECT && pwdata[7:0] == UNLOCK_KEY)
      protect_cnt_ff <= PROTECT_WINDOW;
    else if (access_done && unlocked)
      protect_cnt_ff <= protect_cnt_ff - 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // fuse capture one edge after reset release; straps never enter the async reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_done_ff <= 1'b0;
      cal_lock_ff <= 1'b0;
      center_trim_ff <= 6'h00;
      temp_trim_ff <= 4'h0;
      freq_error_q110_ff <= 11'h000;
    end
    else if (!init_done_ff)
    begin
      init_done_ff <= 1'b1;
      cal_lock_ff <= fuse_cfg.calibration_lock_fuse;
      center_trim_ff <= fuse_cfg.center_trim;
      temp_trim_ff <= fuse_cfg.temp_slope_trim;
      freq_error_q110_ff <= {{3{fuse_cfg.freq_error[7]}}, fuse_cfg.freq_error};
    end
    else if (wr && unlocked && !cal_blocked)
    begin
      if (idx == IDX_FAST_CALIB_A)
        center_trim_ff <= pwdata[5:0];
      if (idx == IDX_FAST_CALIB_B)
        temp_trim_ff <= pwdata[3:0];
    end
  end

  // lock enable loads from the fuse; once set it freezes itself until reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_en_ff <= 1'b0;
    else if (!init_done_ff)
      lock_en_ff <= fuse_cfg.calibration_lock_fuse;
    else if (wr && unlocked && idx == IDX_MAIN_LOCK && !lock_en_ff)
      lock_en_ff <= pwdata[0];
  end

  // protected control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pdiv_ff <= PDIV_RST;
      pen_ff <= PEN_RST;
      clock_output_pin_en_ff <= 1'b0;
      fast_keep_ff <= 1'b0;
      slow_keep_ff <= 1'b0;
    end
    else if (wr && unlocked)
    begin
      if (idx == IDX_MAIN_CTRL_B && !lock_en_ff)
      begin
        pdiv_ff <= pwdata[4:1];
        pen_ff <= pwdata[0];
      end
      if (idx == IDX_MAIN_CTRL_A && !lock_en_ff)
        clock_output_pin_en_ff <= pwdata[CLOCK_OUTPUT_PIN_BIT];
      if (idx == IDX_FAST_CTRL_A)
        fast_keep_ff <= pwdata[KEEP_BIT];
      if (idx == IDX_SLOW_CTRL_A)
        slow_keep_ff <= pwdata[KEEP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source switch: the old root keeps running until the target is stable
  always_comb
  begin
    case (target_ff)
      SRC_FAST: target_stable = fast_stable;
      SRC_SLOW: target_stable = slow_stable;
      SRC_EXT: target_stable = ext_stable;
      default: target_stable = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_state_ff <= SW_IDLE;
      target_ff <= SRC_FAST;
      main_root_sel_ff <= SRC_FAST;
      pending_ff <= 1'b0;
    end
    else
    begin
      case (sw_state_ff)
        SW_IDLE, SW_WAIT:
        begin
          if (sel_wr && pwdata[1:0] != SRC_RSVD && pwdata[1:0] != target_ff)
          begin
            target_ff <= pwdata[1:0];
            pending_ff <= (pwdata[1:0] != main_root_sel_ff);
            sw_state_ff <= (pwdata[1:0] == main_root_sel_ff) ? SW_IDLE :
                           (pwdata[1:0] == SRC_EXT) ? SW_EXT_WAIT : SW_WAIT;
          end
          else if (sw_state_ff == SW_WAIT && target_stable)
          begin
            main_root_sel_ff <= target_ff;
            pending_ff <= 1'b0;
            sw_state_ff <= SW_IDLE;
          end
        end
        SW_EXT_WAIT:
        begin
          // further selects are ignored here; only reset leaves without edges
          if (target_stable)
          begin
            main_root_sel_ff <= target_ff;
            pending_ff <= 1'b0;
            sw_state_ff <= SW_IDLE;
          end
        end
        default: sw_state_ff <= SW_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sleep handling and source requests
  assign keep_allowed = (sleep_mode != SLEEP_POWERDOWN);

  always_comb
  begin
    case (sleep_mode)
      SLEEP_ACTIVE, SLEEP_IDLE: main_run_nxt = 1'b1;
      SLEEP_STANDBY:
        main_run_nxt = periph_req.main_in_standby |
                       ((main_root_sel_ff == SRC_FAST) & fast_keep_ff) |
                       ((main_root_sel_ff == SRC_SLOW) & slow_keep_ff);
      SLEEP_POWERDOWN: main_run_nxt = main_clock_run_ff & nvm_busy;
      default: main_run_nxt = 1'b1;
    endcase
  end

  assign need_fast = (main_clock_run_ff & ((main_root_sel_ff == SRC_FAST) | (pending_ff & (target_ff == SRC_FAST))))
                     | (fast_keep_ff & keep_allowed);
  assign need_slow = (main_clock_run_ff & ((main_root_sel_ff == SRC_SLOW) | (pending_ff & (target_ff == SRC_SLOW))))
                     | periph_req.rtc_enable | periph_req.periodic_interrupt_timer_enable
                     | periph_req.wdt_enable | periph_req.bod_sampled_enable
                     | (slow_keep_ff & keep_allowed);
  assign need_ext = (main_clock_run_ff & ((main_root_sel_ff == SRC_EXT) | (pending_ff & (target_ff == SRC_EXT))))
                    | periph_req.ext_request;

  // oscillator enables and pin mux
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_clock_run_ff <= 1'b1;
      osc_ctrl_ff <= '0;
    end
    else
    begin
      main_clock_run_ff <= main_run_nxt;
      osc_ctrl_ff.fast_enable <= need_fast;
      osc_ctrl_ff.slow_enable <= need_slow;
      osc_ctrl_ff.ext_pin_input <= need_ext;
      osc_ctrl_ff.fast_at_20m <= init_done_ff ? osc_ctrl_ff.fast_at_20m : fuse_cfg.frequency_fuse_select;
    end
  end

  // start-up gates; a kept-running oscillator drops its request only in power-down
  osc_start_gate #(.GATE_CYCLES(FAST_GATE_CYCLES)) u_fast_gate (
    .pclk(pclk),
    .presetn(presetn),
    .request(osc_ctrl_ff.fast_enable),
    .skip_analog(fast_keep_ff & keep_allowed),
    .analog_ready(osc_in.fast_analog_ready),
    .osc_tick(osc_in.fast_tick),
    .stable(fast_stable)
  );
  osc_start_gate #(.GATE_CYCLES(SLOW_GATE_CYCLES)) u_slow_gate (
    .pclk(pclk),
    .presetn(presetn),
    .request(osc_ctrl_ff.slow_enable),
    .skip_analog(1'b1),
    .analog_ready(1'b1),
    .osc_tick(osc_in.slow_tick),
    .stable(slow_stable)
  );
  osc_start_gate #(.GATE_CYCLES(EXT_START_CYCLES)) u_ext_gate (
    .pclk(pclk),
    .presetn(presetn),
    .request(osc_ctrl_ff.ext_pin_input),
    .skip_analog(1'b1),
    .analog_ready(1'b1),
    .osc_tick(osc_in.ext_edge),
    .stable(ext_stable)
  );

  ////////////////////////////////////////////////////////////////////////
  // prescaler counts edges of the current root only
  always_comb
  begin
    case (main_root_sel_ff)
      SRC_SLOW: root_tick = osc_in.slow_tick & slow_stable;
      SRC_EXT: root_tick = osc_in.ext_edge & ext_stable;
      default: root_tick = osc_in.fast_tick & fast_stable;
    endcase
  end
  assign factor = pen_ff ? pdiv_factor(pdiv_ff) : 7'd1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_ff <= 7'h00;
      per_clock_tick_ff <= 1'b0;
      clock_output_pin_ff <= 1'b0;
    end
    else
    begin
      per_clock_tick_ff <= 1'b0;
      clock_output_pin_ff <= 1'b0;
      if (main_clock_run_ff && root_tick)
      begin
        if (div_cnt_ff >= factor - 7'd1)
        begin
          div_cnt_ff <= 7'h00;
          per_clock_tick_ff <= 1'b1;
          clock_output_pin_ff <= clock_output_pin_en_ff;
        end
        else
          div_cnt_ff <= div_cnt_ff + 7'd1;
      end
    end
  end

  // 1.024 kHz from slow oscillator by divide of thirty-two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      khz_cnt_ff <= '0;
      rtc_clock_tick_ff <= 1'b0;
      watchdog_clock_ff <= 1'b0;
      brownout_clock_ff <= 1'b0;
    end
    else
    begin
      rtc_clock_tick_ff <= 1'b0;
      watchdog_clock_ff <= 1'b0;
      brownout_clock_ff <= 1'b0;
      if (osc_in.slow_tick && slow_stable)
      begin
        khz_cnt_ff <= khz_cnt_ff + 1'b1;
        if (&khz_cnt_ff)
        begin
          rtc_clock_tick_ff <= periph_req.rtc_enable | periph_req.periodic_interrupt_timer_enable;
          watchdog_clock_ff <= periph_req.wdt_enable;
          brownout_clock_ff <= periph_req.bod_sampled_enable;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_unprot_ctrlb;
    wr && idx == IDX_MAIN_CTRL_B && !unlocked;
  endsequence

  a_main_run_awake:
    assert property ((sleep_mode == SLEEP_ACTIVE || sleep_mode == SLEEP_IDLE) |=> main_clock_run_ff)
      else $error("main clock stopped while awake");
  a_pd_nvm_wait:
    assert property ((sleep_mode == SLEEP_POWERDOWN && nvm_busy && main_clock_run_ff) |=> main_clock_run_ff)
      else $error("main clock stopped during nvm operation");
  a_ext_pin_unused:
    assert property ((!periph_req.ext_request && main_root_sel_ff != SRC_EXT && target_ff != SRC_EXT) [*2]
                     |-> !osc_ctrl_ff.ext_pin_input)
      else $error("external pin held as clock input without request");
  a_ext_wait_locked:
    assert property ((sw_state_ff == SW_EXT_WAIT && !ext_stable) |=> (sw_state_ff == SW_EXT_WAIT && target_ff == SRC_EXT))
      else $error("select changed while waiting for external clock");
  a_pending_flag:
    assert property (pending_ff == (sw_state_ff != SW_IDLE))
      else $error("switch flag disagrees with switch state");
  a_reset_defaults:
    assert property (!init_done_ff |-> (pdiv_ff == PDIV_RST && pen_ff && main_root_sel_ff == SRC_FAST))
      else $error("wrong clock setup after reset");
  a_cal_block:
    assert property ((wr && unlocked && idx == IDX_FAST_CALIB_A && cal_blocked && init_done_ff) |=> $stable(center_trim_ff))
      else $error("locked calibration changed");
  a_ctrlb_protect:
    assert property (s_unprot_ctrlb |=> ($stable(pdiv_ff) && $stable(pen_ff)))
      else $error("prescaler changed without unlock");
  a_switch_hold:
    assert property ((pending_ff && !target_stable) |=> $stable(main_root_sel_ff))
      else $error("root switched before target stable");
  a_div_range:
    assert property ((div_cnt_ff < 7'd64) && (factor >= 7'd1) && (factor <= 7'd64))
      else $error("prescaler out of range");
endmodule // main_clock_controller

// [src/clk_ctrl_pkg.sv]
// shared constants, types and helpers of the main clock controller
package clk_ctrl_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_MAIN_CTRL_A = 8'h00;
  localparam logic [7:0] IDX_MAIN_CTRL_B = 8'h01;
  localparam logic [7:0] IDX_MAIN_LOCK = 8'h02;
  localparam logic [7:0] IDX_MAIN_STATUS = 8'h03;
  localparam logic [7:0] IDX_FAST_CTRL_A = 8'h10;
  localparam logic [7:0] IDX_FAST_CALIB_A = 8'h11;
  localparam logic [7:0] IDX_FAST_CALIB_B = 8'h12;
  localparam logic [7:0] IDX_SLOW_CTRL_A = 8'h18;
  localparam logic [7:0] IDX_FREQ_ERROR = 8'h1a;
  localparam logic [7:0] IDX_PROTECT = 8'h20;
  // field positions
  localparam int unsigned CLOCK_OUTPUT_PIN_BIT = 7;
  localparam int unsigned KEEP_BIT = 1;
  localparam int unsigned CAL_LOCK_BIT = 7;
  localparam int unsigned EXT_CLOCK_STARTED_BIT = 7;
  localparam int unsigned SLOW_STABLE_BIT = 5;
  localparam int unsigned FAST_STABLE_BIT = 4;
  // reset values
  localparam logic [3:0] PDIV_RST = 4'h8;
  localparam logic PEN_RST = 1'b1;
  // main source codes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_RSVD = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  // timing counts
  localparam int unsigned FAST_GATE_CYCLES = 4;
  localparam int unsigned SLOW_GATE_CYCLES = 4;
  localparam int unsigned EXT_START_CYCLES = 2;
  localparam int unsigned KHZ_DIV_W = 5;
  localparam logic [2:0] PROTECT_WINDOW = 3'h4;
  localparam logic [7:0] UNLOCK_KEY_DEF = 8'h5a;

  typedef enum logic [1:0] {SLEEP_ACTIVE, SLEEP_IDLE, SLEEP_STANDBY, SLEEP_POWERDOWN} sleep_mode_t;

  typedef struct packed {
    logic main_in_standby;
    logic rtc_enable;
    logic periodic_interrupt_timer_enable;
    logic wdt_enable;
    logic bod_sampled_enable;
    logic ext_request;
  } periph_req_t;

  typedef struct packed {
    logic frequency_fuse_select;
    logic calibration_lock_fuse;
    logic [5:0] center_trim;
    logic [3:0] temp_slope_trim;
    logic [7:0] freq_error;
  } fuse_cfg_t;

  typedef struct packed {
    logic fast_analog_ready;
    logic fast_tick;
    logic slow_tick;
    logic ext_edge;
  } osc_in_t;

  typedef struct packed {
    logic fast_enable;
    logic slow_enable;
    logic ext_pin_input;
    logic fast_at_20m;
  } osc_ctrl_t;

  // prescaler ratio; reserved codes fall back to divide by two
  function automatic logic [6:0] pdiv_factor(input logic [3:0] code);
    case (code)
      4'h0: pdiv_factor = 7'd2;
      4'h1: pdiv_factor = 7'd4;
      4'h2: pdiv_factor = 7'd8;
      4'h3: pdiv_factor = 7'd16;
      4'h4: pdiv_factor = 7'd32;
      4'h5: pdiv_factor = 7'd64;
      4'h8: pdiv_factor = 7'd6;
      4'h9: pdiv_factor = 7'd10;
      4'ha: pdiv_factor = 7'd12;
      4'hb: pdiv_factor = 7'd24;
      4'hc: pdiv_factor = 7'd48;
      default: pdiv_factor = 7'd2;
    endcase
  endfunction
endpackage

// [src/osc_start_gate.sv]
// start-up gate: holds an oscillator output closed for a number of its cycles
`timescale 1ns/1ps
module osc_start_gate #(
  parameter int unsigned GATE_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic request,
  input wire logic skip_analog,
  input wire logic analog_ready,
  input wire logic osc_tick,
  output logic stable
);
  localparam int unsigned CW = $clog2(GATE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(GATE_CYCLES - 1);
  logic [CW-1:0] cnt_ff;
  logic armed_ff;

  // a dropped request restarts the whole start-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= '0;
      armed_ff <= 1'b0;
      stable <= 1'b0;
    end
    else if (!request)
    begin
      cnt_ff <= '0;
      armed_ff <= 1'b0;
      stable <= 1'b0;
    end
    else if (!armed_ff)
      armed_ff <= analog_ready | skip_analog;
    else if (!stable && osc_tick)
    begin
      if (cnt_ff == LAST)
        stable <= 1'b1;
      else
        cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule // osc_start_gate

// [test/osc_model.sv]
// oscillator model: fast, slow and external source ticks
`timescale 1ns/1ps
module osc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire clk_ctrl_pkg::osc_ctrl_t ctl,
  input wire logic ext_run,
  output clk_ctrl_pkg::osc_in_t oin
);
  import clk_ctrl_pkg::*;
  logic [3:0] cnt_ff;
  logic [3:0] warm_ff;
  // shared phase counter; a source ticks only while enabled, so idle sources stand still
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= cnt_ff + 4'h1;
  // analog warm-up restarts whenever the fast source is switched off
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      warm_ff <= 4'h0;
    else if (!ctl.fast_enable)
      warm_ff <= 4'h0;
    else if (!warm_ff[3])
      warm_ff <= warm_ff + 4'h1;
  assign oin.fast_analog_ready = warm_ff[3];
  assign oin.fast_tick = ctl.fast_enable & cnt_ff[0];
  assign oin.slow_tick = ctl.slow_enable & (cnt_ff[1:0] == 2'h3);
  // pin gives edges only once turned into a clock input and the far clock runs
  assign oin.ext_edge = ctl.ext_pin_input & ext_run & (cnt_ff[1:0] == 2'h1);
endmodule // osc_model

// [test/testbench.sv]
// self-checking testbench of the main clock controller
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; $display("ERROR %0t got %h", $time, a); end end
`define WT(c) begin k = 0; while ((c) !== 1'b1 && k < 3000) begin @(posedge pclk); k++; end if (k >= 3000) begin \
fails++; $display("ERROR %0t wait ran out", $time); end_sim(); end end
module testbench;
  import clk_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, nvm_busy, ext_run, pready_ff, pslverr_ff, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_ff, rd;
  logic [1:0] main_root_sel_ff;
  logic main_clock_run_ff, per_clock_tick_ff, clock_output_pin_ff;
  logic rtc_clock_tick_ff, watchdog_clock_ff, brownout_clock_ff;
  logic [10:0] freq_error_q110_ff;
  sleep_mode_t sleep_mode;
  periph_req_t periph_req;
  fuse_cfg_t fuse_cfg;
  osc_in_t osc_in;
  osc_ctrl_t osc_ctrl_ff;
  int fails, n_compared, k;
  main_clock_controller main_clock_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .sleep_mode(sleep_mode), .nvm_busy(nvm_busy), .periph_req(periph_req),
    .fuse_cfg(fuse_cfg), .osc_in(osc_in), .osc_ctrl_ff(osc_ctrl_ff), .main_root_sel_ff(main_root_sel_ff),
    .main_clock_run_ff(main_clock_run_ff), .per_clock_tick_ff(per_clock_tick_ff),
    .clock_output_pin_ff(clock_output_pin_ff), .rtc_clock_tick_ff(rtc_clock_tick_ff),
    .watchdog_clock_ff(watchdog_clock_ff), .brownout_clock_ff(brownout_clock_ff),
    .freq_error_q110_ff(freq_error_q110_ff));
  osc_model osc_model_i (.pclk(pclk), .presetn(presetn), .ctl(osc_ctrl_ff), .ext_run(ext_run), .oin(osc_in));
  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  // one apb transfer; entered just after a rising edge, read data lands in rd
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    `WT(pready_ff)
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // key write opens the protected window
  task automatic unlock;
    xfer(1'b1, IDX_PROTECT, {24'h00_0000, UNLOCK_KEY_DEF});
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    nvm_busy = 1'b0;
    ext_run = 1'b0;
    sleep_mode = SLEEP_ACTIVE;
    periph_req = '0;
    fails = 0;
    n_compared = 0;
    fuse_cfg = '{1'b1, 1'b0, 6'h2a, 4'h9, 8'h85};
    repeat (3) @(posedge pclk);
    `CHK(main_clock_run_ff, 1'b1)
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK(main_root_sel_ff, SRC_FAST)
    `CHK(osc_ctrl_ff.fast_at_20m, 1'b1)
    `CHK(freq_error_q110_ff, 11'h785)
    xfer(1'b0, IDX_MAIN_CTRL_B, 32'h0000_0000);
    `CHK(rd, 32'h0000_0011)
    xfer(1'b0, IDX_FAST_CALIB_A, 32'h0000_0000);
    `CHK(rd, 32'h0000_002a)
    xfer(1'b0, IDX_FAST_CALIB_B, 32'h0000_0000);
    `CHK(rd, 32'h0000_0009)
    tdone("reset");
    // protected writes with and without the key, then an unmapped place
    xfer(1'b1, IDX_MAIN_CTRL_B, 32'h0000_0001);
    xfer(1'b0, IDX_MAIN_CTRL_B, 32'h0000_0000);
    `CHK(rd, 32'h0000_0011)
    unlock();
    xfer(1'b1, IDX_MAIN_CTRL_B, 32'h0000_000b);
    xfer(1'b0, IDX_MAIN_CTRL_B, 32'h0000_0000);
    `CHK(rd, 32'h0000_000b)
    xfer(1'b0, 8'h04, 32'h0000_0000);
    `CHK(err, 1'b1)
    tdone("protect");
    // sleep modes
    sleep_mode <= SLEEP_STANDBY;
    `WT(main_clock_run_ff === 1'b0)
    `CHK(main_clock_run_ff, 1'b0)
    periph_req.main_in_standby <= 1'b1;
    `WT(main_clock_run_ff === 1'b1)
    `CHK(main_clock_run_ff, 1'b1)
    periph_req.main_in_standby <= 1'b0;
    nvm_busy <= 1'b1;
    sleep_mode <= SLEEP_POWERDOWN;
    repeat (20) @(posedge pclk);
    `CHK(main_clock_run_ff, 1'b1)
    nvm_busy <= 1'b0;
    `WT(main_clock_run_ff === 1'b0)
    sleep_mode <= SLEEP_IDLE;
    `WT(main_clock_run_ff === 1'b1)
    repeat (20) @(posedge pclk);
    `CHK(main_clock_run_ff, 1'b1)
    sleep_mode <= SLEEP_ACTIVE;
    tdone("sleep");
    // watchdog request brings the slow clock
    periph_req.wdt_enable <= 1'b1;
    periph_req.rtc_enable <= 1'b1;
    `WT(watchdog_clock_ff === 1'b1)
    `CHK(osc_ctrl_ff.slow_enable, 1'b1)
    `CHK(rtc_clock_tick_ff, 1'b1)
    `CHK(brownout_clock_ff, 1'b0)
    periph_req <= '0;
    `WT(osc_ctrl_ff.slow_enable === 1'b0)
    tdone("unit clock");
    // switch to slow, pending while the new source warms up
    unlock();
    xfer(1'b1, IDX_MAIN_CTRL_A, 32'h0000_0001);
    xfer(1'b0, IDX_MAIN_STATUS, 32'h0000_0000);
    `CHK(rd[0], 1'b1)
    `CHK(main_root_sel_ff, SRC_FAST)
    `WT(main_root_sel_ff === SRC_SLOW)
    xfer(1'b0, IDX_MAIN_STATUS, 32'h0000_0000);
    `CHK(rd[0], 1'b0)
    // external clock absent: switch hangs and later selects are ignored
    unlock();
    xfer(1'b1, IDX_MAIN_CTRL_A, 32'h0000_0003);
    repeat (40) @(posedge pclk);
    `CHK(osc_ctrl_ff.ext_pin_input, 1'b1)
    `CHK(main_root_sel_ff, SRC_SLOW)
    unlock();
    xfer(1'b1, IDX_MAIN_CTRL_A, 32'h0000_0000);
    repeat (40) @(posedge pclk);
    `CHK(main_root_sel_ff, SRC_SLOW)
    xfer(1'b0, IDX_MAIN_STATUS, 32'h0000_0000);
    `CHK(rd[7], 1'b0)
    ext_run <= 1'b1;
    `WT(main_root_sel_ff === SRC_EXT)
    xfer(1'b0, IDX_MAIN_STATUS, 32'h0000_0000);
    `CHK(rd[7], 1'b1)
    `WT(osc_ctrl_ff.slow_enable === 1'b0)
    `CHK(osc_ctrl_ff.fast_enable, 1'b0)
    // keep bit holds the fast source on in standby though nothing uses it
    unlock();
    xfer(1'b1, IDX_FAST_CTRL_A, 32'h0000_0002);
    sleep_mode <= SLEEP_STANDBY;
    repeat (4) @(posedge pclk);
    `CHK(osc_ctrl_ff.fast_enable, 1'b1)
    `CHK(osc_ctrl_ff.ext_pin_input, 1'b0)
    tdone("switch");
    // reset in mid-run returns to the fast source
    presetn <= 1'b0;
    sleep_mode <= SLEEP_ACTIVE;
    @(posedge pclk);
    `CHK(main_root_sel_ff, SRC_FAST)
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    xfer(1'b0, IDX_MAIN_CTRL_B, 32'h0000_0000);
    `CHK(rd, 32'h0000_0011)
    // fast tick every second edge, divide by six: twelve edges a period
    `WT(per_clock_tick_ff)
    @(posedge pclk);
    `WT(per_clock_tick_ff)
    `CHK(k, 11)
    // reserved select with clock out, retune under a slow prescaler, then lock
    unlock();
    xfer(1'b1, IDX_MAIN_CTRL_A, 32'h0000_0082);
    xfer(1'b1, IDX_MAIN_CTRL_B, 32'h0000_000b);
    xfer(1'b1, IDX_FAST_CALIB_A, 32'h0000_0015);
    xfer(1'b1, IDX_MAIN_CTRL_B, 32'h0000_0011);
    unlock();
    xfer(1'b1, IDX_MAIN_LOCK, 32'h0000_0001);
    xfer(1'b1, IDX_FAST_CALIB_A, 32'h0000_0007);
    xfer(1'b0, IDX_MAIN_CTRL_A, 32'h0000_0000);
    `CHK(rd, 32'h0000_0080)
    xfer(1'b0, IDX_FAST_CALIB_A, 32'h0000_0000);
    `CHK(rd, 32'h0000_0015)
    xfer(1'b0, IDX_MAIN_CTRL_B, 32'h0000_0000);
    `CHK(rd, 32'h0000_0011)
    `WT(clock_output_pin_ff)
    `CHK(clock_output_pin_ff, 1'b1)
    tdone("rereset");
    end_sim();
  end
endmodule // testbench
